// [shared/rcdr_pkg.sv]
package rcdr_pkg;

   // register addresses on the internal register bus
   localparam logic [15:0] STATUS_ADDR = 16'h1800;
   localparam logic [15:0] CONTROL_ADDR = 16'h1801;

   // reset-cause field positions
   localparam int POR_BIT = 7;
   localparam int PIN_BIT = 6;
   localparam int WDOG_BIT = 5;
   localparam int OPCODE_BIT = 4;
   localparam int ADDR_BIT = 3;
   localparam int LOW_VOLT_BIT = 1;

   // forced reset bit of the debug control register
   localparam int FORCE_BIT = 0;

   // reset values and the constant read value of the control register
   localparam logic [7:0] STATUS_POR_VALUE = 8'h82;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // designated illegal gaps on the small-memory variants
   localparam logic [15:0] GAP1_LO = 16'h0440;
   localparam logic [15:0] GAP1_HI = 16'h17FF;
   localparam logic [15:0] GAP2_LO = 16'h1834;
   localparam logic [15:0] GAP2_HI = 16'hBFFF;

   // system reset pulse length, rounded up to whole clocks
   localparam int CLK_PERIOD_NS = 8;
   localparam int RESET_HOLD_NS = 80;
   localparam int RESET_HOLD_CYCLES =
      (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] HOLD_LAST = 4'(RESET_HOLD_CYCLES - 1);
   localparam logic [3:0] HOLD_ZERO = 4'h0;

   // sources other than low voltage and debug force, ordered as status bits 6 down to 3
   typedef struct packed {
      logic pin;
      logic watchdog;
      logic illegal_opcode;
      logic illegal_address;
   } rcdr_other_type;

   // everything that may start a system reset in one cycle
   typedef struct packed {
      logic low_voltage;
      logic debug_force;
      rcdr_other_type other;
   } rcdr_cause_type;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_RESET = 2'b01
   } rcdr_state_type;

endpackage : rcdr_pkg

// [core/rcdr_illegal_addr.sv]
`timescale 1ns/100ps
module rcdr_illegal_addr #(
   parameter bit SMALL_MEMORY = 1'b1
) (
   input wire logic [15:0] addr_i,
   input wire logic access_i,
   output logic hit_o
);
   import rcdr_pkg::*;

   logic in_gap;

   // register areas lie outside both gaps, so their holes never hit
   always_comb begin
      in_gap = ((addr_i >= GAP1_LO) && (addr_i <= GAP1_HI)) ||
               ((addr_i >= GAP2_LO) && (addr_i <= GAP2_HI));
      hit_o = SMALL_MEMORY && access_i && in_gap;
   end

endmodule : rcdr_illegal_addr

// [core/rcdr_cause_encode.sv]
`timescale 1ns/100ps
module rcdr_cause_encode #(
   parameter bit SMALL_MEMORY = 1'b1
) (
   input wire rcdr_pkg::rcdr_cause_type cause_i,
   input wire logic [7:0] status_i,
   output logic [7:0] next_status_o
);
   import rcdr_pkg::*;

   logic [3:0] other_bits;
   logic [3:0] masked;

   assign other_bits = cause_i.other;

   // one flag per other source; the address flag exists on small parts only
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_flag
         if (i == 0) begin : g_addr
            assign masked[i] = other_bits[i] & SMALL_MEMORY;
         end else begin : g_plain
            assign masked[i] = other_bits[i];
         end
      end
   endgenerate

   // low voltage wins and keeps the power-on flag; debug alone sets nothing
   always_comb begin
      next_status_o = READ_ZERO;
      if (cause_i.low_voltage) begin
         next_status_o[POR_BIT] = status_i[POR_BIT];
         next_status_o[LOW_VOLT_BIT] = 1'b1;
      end else begin
         next_status_o[PIN_BIT:ADDR_BIT] = masked;
      end
   end

endmodule : rcdr_cause_encode

// [core/rcdr_top.sv]
`timescale 1ns/100ps
// Operation
// - six read-only cause flags in one byte name the latest reset source
// - a debug forced reset leaves every cause flag cleared
// - any write to the status address restarts watchdog, flags unchanged
// - power-on sets bit 7 and the low-voltage flag, clears the others
// - low-voltage reset sets its flag, keeps power-on flag, clears rest
// - other resets set flags of active sources, clear power and voltage
// - bit 6 marks a reset from a low level on the reset pin
// - bit 5 marks watchdog timeout; none while watchdog is disabled
// - undefined opcodes, disabled stop or background reset and set bit 4
// - access to a designated illegal range resets and sets bit 3
// - small parts: gaps 0440-17FF and 1834-BFFF are illegal
// - holes inside register areas are never illegal addresses
// - the illegal-address flag exists only on small-memory variants
// - enabled low-voltage trip resets and sets bit 1
// - user program writes to the debug control register are ignored
// - the debug control register always reads zero
// - a debug write of one to bit 0 forces a full system reset
module rcdr_top #(
   parameter bit SMALL_MEMORY = 1'b1
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic [15:0] bus_addr_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_debug_i,
   input wire logic reset_pin_n_i,
   input wire logic watchdog_timeout_i,
   input wire logic watchdog_enable_i,
   input wire logic opcode_undefined_i,
   input wire logic stop_exec_i,
   input wire logic stop_mode_enable_i,
   input wire logic enter_background_instruction_i,
   input wire logic active_background_enable_i,
   input wire logic low_voltage_trip_i,
   input wire logic low_voltage_reset_enable_i,
   output logic [7:0] bus_rdata_o,
   output logic watchdog_restart_o,
   output logic system_reset_o,
   output logic [7:0] reset_cause_status_o
);
   import rcdr_pkg::*;

   rcdr_state_type state;
   rcdr_state_type next_state;
   logic [3:0] hold_count;
   logic [3:0] next_hold_count;
   logic [7:0] status;
   logic [7:0] next_status;
   logic [7:0] encoded_status;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic restart;
   logic next_restart;
   logic sel_status;
   logic sel_control;
   logic user_access;
   logic illegal_hit;
   logic any_cause;
   logic enter_reset;
   rcdr_cause_type cause;

   // address decode of the two registers
   assign sel_status = (bus_addr_i == STATUS_ADDR);
   assign sel_control = (bus_addr_i == CONTROL_ADDR);
   assign user_access = (bus_rd_i || bus_wr_i) && !bus_debug_i;

   // only program accesses can trip the illegal-address detector
   rcdr_illegal_addr #(
      .SMALL_MEMORY(SMALL_MEMORY)
   ) u_illegal_addr (
      .addr_i(bus_addr_i),
      .access_i(user_access),
      .hit_o(illegal_hit)
   );

   // gather every reset source seen this cycle
   always_comb begin
      cause.low_voltage = low_voltage_trip_i &&
                          low_voltage_reset_enable_i;
      cause.debug_force = bus_wr_i && sel_control && bus_debug_i &&
                          bus_wdata_i[FORCE_BIT];
      cause.other.pin = !reset_pin_n_i;
      cause.other.watchdog = watchdog_timeout_i &&
                             watchdog_enable_i;
      cause.other.illegal_opcode = opcode_undefined_i ||
         (stop_exec_i && !stop_mode_enable_i) ||
         (enter_background_instruction_i &&
          !active_background_enable_i);
      cause.other.illegal_address = illegal_hit;
   end

   assign any_cause = cause.low_voltage || cause.debug_force ||
                      (cause.other != 4'h0);
   assign enter_reset = ce_i && (state == ST_RUN) && any_cause;

   // next flag byte for whatever reset is being started
   rcdr_cause_encode #(
      .SMALL_MEMORY(SMALL_MEMORY)
   ) u_cause_encode (
      .cause_i(cause),
      .status_i(status),
      .next_status_o(encoded_status)
   );

   // reset sequencer: a fixed-length system reset per detected cause
   always_comb begin
      next_state = state;
      next_hold_count = hold_count;
      case (state)
         ST_RUN: begin
            if (any_cause) begin
               next_state = ST_RESET;
               next_hold_count = HOLD_LAST;
            end
         end
         ST_RESET: begin
            // the last count returns to ST_RUN; sources still active in the next cycle restart the sequence
            if (hold_count == HOLD_ZERO) begin
               next_state = ST_RUN;
            end else begin
               next_hold_count = hold_count - 4'h1;
            end
         end
         default: begin
            next_state = ST_RUN;
            next_hold_count = HOLD_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_RUN;
         hold_count <= HOLD_ZERO;
      end else if (ce_i) begin
         state <= next_state;
         hold_count <= next_hold_count;
      end
   end

   assign system_reset_o = (state == ST_RESET);

   // cause flags change only when a reset starts; bus writes never touch them
   always_comb begin
      next_status = status;
      if ((state == ST_RUN) && any_cause) begin
         next_status = encoded_status;
      end
      next_status[2] = 1'b0;
      next_status[0] = 1'b0;
   end

   // power-up is the asynchronous reset itself
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         status <= STATUS_POR_VALUE;
      end else if (ce_i) begin
         status <= next_status;
      end
   end

   assign reset_cause_status_o = status;

   // read data and watchdog restart, both registered for clean timing
   always_comb begin
      next_rdata = READ_ZERO;
      if (bus_rd_i && sel_status) begin
         next_rdata = status;
      end else if (bus_rd_i && sel_control) begin
         next_rdata = CONTROL_RESET;
      end
      next_restart = bus_wr_i && sel_status;
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata <= READ_ZERO;
         restart <= 1'b0;
      end else if (ce_i) begin
         rdata <= next_rdata;
         restart <= next_restart;
      end
   end

   assign bus_rdata_o = rdata;
   assign watchdog_restart_o = restart;

   // checks on the outputs against their causes
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   ctrl_reads_zero_a: assert property (
      ce_i && bus_rd_i && sel_control |=> bus_rdata_o == READ_ZERO)
      else $error("debug control register read not zero");

   reserved_bits_a: assert property (
      reset_cause_status_o[2] == 1'b0 && reset_cause_status_o[0] == 1'b0)
      else $error("reserved status bit set");

   status_write_restart_a: assert property (
      ce_i && bus_wr_i && sel_status |=> watchdog_restart_o)
      else $error("status write did not restart watchdog");

   status_write_stable_a: assert property (
      ce_i && bus_wr_i && sel_status && !enter_reset
      |=> $stable(reset_cause_status_o))
      else $error("status write changed the flags");

   debug_flags_clear_a: assert property (
      enter_reset && cause.debug_force && !cause.low_voltage &&
      cause.other == 4'h0 |=> reset_cause_status_o == READ_ZERO)
      else $error("debug forced reset left a flag set");

   low_volt_keeps_por_a: assert property (
      enter_reset && cause.low_voltage
      |=> reset_cause_status_o[POR_BIT] == $past(status[POR_BIT]) &&
          reset_cause_status_o[LOW_VOLT_BIT] &&
          reset_cause_status_o[PIN_BIT:ADDR_BIT] == 4'h0)
      else $error("low-voltage reset flags wrong");

   user_write_ignored_a: assert property (
      ce_i && state == ST_RUN && bus_wr_i && sel_control &&
      !bus_debug_i && !any_cause |=> !system_reset_o)
      else $error("user write forced a reset");

   debug_force_reset_a: assert property (
      ce_i && state == ST_RUN && cause.debug_force
      |=> system_reset_o [*8])
      else $error("debug force did not hold system reset");

   wdog_disabled_a: assert property (
      enter_reset && !watchdog_enable_i && !cause.low_voltage
      |=> !reset_cause_status_o[WDOG_BIT])
      else $error("watchdog flag set while disabled");

   pin_flag_a: assert property (
      enter_reset && !reset_pin_n_i && !cause.low_voltage
      |=> reset_cause_status_o[PIN_BIT] &&
          !reset_cause_status_o[POR_BIT] &&
          !reset_cause_status_o[LOW_VOLT_BIT])
      else $error("pin reset flags wrong");

   illegal_addr_a: assert property (
      enter_reset && illegal_hit && !cause.low_voltage
      |=> reset_cause_status_o[ADDR_BIT])
      else $error("illegal address flag missing");

   // remaining cause flags, held flags, variants, register areas and the start of the reset
   opcode_flag_a: assert property (
      enter_reset && cause.other.illegal_opcode && !cause.low_voltage
      |=> reset_cause_status_o[OPCODE_BIT])
      else $error("illegal opcode flag missing");

   low_volt_flag_a: assert property (
      enter_reset && cause.low_voltage
      |=> reset_cause_status_o[LOW_VOLT_BIT])
      else $error("low-voltage flag missing");

   other_clears_power_a: assert property (
      enter_reset && !cause.low_voltage
      |=> !reset_cause_status_o[POR_BIT] &&
          !reset_cause_status_o[LOW_VOLT_BIT])
      else $error("power flags left set by another reset");

   flags_hold_a: assert property (
      !enter_reset |=> $stable(reset_cause_status_o))
      else $error("cause flags changed without a reset");

   no_addr_flag_a: assert property (
      !SMALL_MEMORY |-> !reset_cause_status_o[ADDR_BIT])
      else $error("address flag set on a large variant");

   reg_area_legal_a: assert property (
      bus_addr_i >= STATUS_ADDR && bus_addr_i < GAP2_LO |-> !illegal_hit)
      else $error("register area access flagged illegal");

   reset_starts_full_a: assert property (
      enter_reset |=> system_reset_o && hold_count == HOLD_LAST)
      else $error("system reset did not start with a full count");

   // a counter bounds the reset, a long repetition would slow the tools
   reset_ends_a: assert property (
      system_reset_o && ce_i && hold_count == HOLD_ZERO |=> !system_reset_o)
      else $error("system reset outlived its count");

   rdata_idle_zero_a: assert property (
      ce_i && !bus_rd_i |=> bus_rdata_o == READ_ZERO)
      else $error("read data not zero without a read");

   restart_only_write_a: assert property (
      ce_i && !(bus_wr_i && sel_status) |=> !watchdog_restart_o)
      else $error("watchdog restart without a status write");

   ce_freeze_a: assert property (
      !ce_i |=> $stable(reset_cause_status_o) && $stable(system_reset_o))
      else $error("state moved while the clock enable was low");

   cover_low_volt_c: cover property (enter_reset && cause.low_voltage);
   cover_debug_c: cover property (enter_reset && cause.debug_force);
   cover_restart_c: cover property (ce_i && bus_wr_i && sel_status);
   cover_opcode_c: cover property (enter_reset && cause.other.illegal_opcode);
   cover_ce_freeze_c: cover property (!ce_i && any_cause);

endmodule : rcdr_top

// [tb/rcdr_dbg_host.sv]
`timescale 1ns/100ps
// behavioural serial debug host; each request ends in one debug bus write
module rcdr_dbg_host (
   input wire logic clk_sys_i,
   input wire logic go_i,
   input wire logic [7:0] data_i,
   output logic wr_o,
   output logic [15:0] addr_o,
   output logic [7:0] wdata_o
);
   import rcdr_pkg::*;
   initial begin
      wr_o = 1'b0;
      addr_o = 16'h0000;
      wdata_o = 8'h00;
   end
   // memory write lands one cycle after the request; released lines toggle
   always @(posedge clk_sys_i) begin
      wr_o <= go_i;
      addr_o <= go_i ? CONTROL_ADDR : ~addr_o;
      wdata_o <= go_i ? data_i : ~wdata_o;
   end
endmodule : rcdr_dbg_host

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
   import rcdr_pkg::*;
   // src bits: pin,wdog_to,wdog_en,opc,stop,stop_en,bg,bg_en,lv,lv_en
   typedef struct packed {
      logic [9:0] src;
      logic acc;
      logic [15:0] addr;
      logic hit;
      logic [7:0] status;
   } rcdr_row_type;
   localparam rcdr_row_type ROWS [20] = '{
      '{10'h003, 1'b0, 16'h0000, 1'b1, 8'h82},
      '{10'h200, 1'b0, 16'h0000, 1'b1, 8'h40},
      '{10'h180, 1'b0, 16'h0000, 1'b1, 8'h20},
      '{10'h100, 1'b0, 16'h0000, 1'b0, 8'h20},
      '{10'h040, 1'b0, 16'h0000, 1'b1, 8'h10},
      '{10'h020, 1'b0, 16'h0000, 1'b1, 8'h10},
      '{10'h030, 1'b0, 16'h0000, 1'b0, 8'h10},
      '{10'h008, 1'b0, 16'h0000, 1'b1, 8'h10},
      '{10'h00C, 1'b0, 16'h0000, 1'b0, 8'h10},
      '{10'h000, 1'b1, 16'h0440, 1'b1, 8'h08},
      '{10'h000, 1'b1, 16'h17FF, 1'b1, 8'h08},
      '{10'h000, 1'b1, 16'h1834, 1'b1, 8'h08},
      '{10'h000, 1'b1, 16'hBFFF, 1'b1, 8'h08},
      '{10'h000, 1'b1, 16'h1820, 1'b0, 8'h08},
      '{10'h000, 1'b1, 16'h043F, 1'b0, 8'h08},
      '{10'h000, 1'b1, 16'hC000, 1'b0, 8'h08},
      '{10'h380, 1'b0, 16'h0000, 1'b1, 8'h60},
      '{10'h002, 1'b0, 16'h0000, 1'b0, 8'h60},
      '{10'h003, 1'b0, 16'h0000, 1'b1, 8'h02},
      '{10'h203, 1'b0, 16'h0000, 1'b1, 8'h02}};
   localparam logic [7:0] HOLD_N = 8'(RESET_HOLD_CYCLES);
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce = 1'b1;
   logic [9:0] src = 10'h000;
   logic t_wr = 1'b0, t_rd = 1'b0, go = 1'b0;
   logic [15:0] t_addr = 16'h0000;
   logic [7:0] t_wdata = 8'h00, go_data = 8'h00, v;
   logic h_wr, restart, sys_rst, sys_rst_l;
   logic [15:0] h_addr;
   logic [7:0] h_wdata, rdata, status, status_l;
   int error_cnt = 0, compares = 0, cyc = 0, n, n_l;
   always #4 clk_sys_i = ~clk_sys_i;
   rcdr_dbg_host host (.clk_sys_i(clk_sys_i), .go_i(go), .data_i(go_data),
      .wr_o(h_wr), .addr_o(h_addr), .wdata_o(h_wdata));
   // host owns the bus only while its write strobe is up
   rcdr_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce),
      .bus_addr_i(h_wr ? h_addr : t_addr), .bus_wr_i(t_wr | h_wr),
      .bus_rd_i(t_rd), .bus_wdata_i(h_wr ? h_wdata : t_wdata),
      .bus_debug_i(h_wr), .reset_pin_n_i(!src[9]),
      .watchdog_timeout_i(src[8]), .watchdog_enable_i(src[7]),
      .opcode_undefined_i(src[6]), .stop_exec_i(src[5]),
      .stop_mode_enable_i(src[4]),
      .enter_background_instruction_i(src[3]),
      .active_background_enable_i(src[2]), .low_voltage_trip_i(src[1]),
      .low_voltage_reset_enable_i(src[0]), .bus_rdata_o(rdata),
      .watchdog_restart_o(restart), .system_reset_o(sys_rst),
      .reset_cause_status_o(status));
   // large-memory variant on the same stimulus: no address detection
   rcdr_top #(.SMALL_MEMORY(1'b0)) dut_large (.clk_sys_i(clk_sys_i),
      .rst_i(rst_i), .ce_i(ce), .bus_addr_i(h_wr ? h_addr : t_addr),
      .bus_wr_i(t_wr | h_wr), .bus_rd_i(t_rd),
      .bus_wdata_i(h_wr ? h_wdata : t_wdata), .bus_debug_i(h_wr),
      .reset_pin_n_i(!src[9]), .watchdog_timeout_i(src[8]),
      .watchdog_enable_i(src[7]), .opcode_undefined_i(src[6]),
      .stop_exec_i(src[5]), .stop_mode_enable_i(src[4]),
      .enter_background_instruction_i(src[3]),
      .active_background_enable_i(src[2]), .low_voltage_trip_i(src[1]),
      .low_voltage_reset_enable_i(src[0]), .bus_rdata_o(),
      .watchdog_restart_o(), .system_reset_o(sys_rst_l),
      .reset_cause_status_o(status_l));
   task automatic finish_test;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one strobe cycle; the answer is settled just after the taking edge
   task automatic access(input logic wr, input logic [15:0] a,
         input logic [7:0] d);
      @(posedge clk_sys_i);
      t_wr <= wr;
      t_rd <= !wr;
      t_addr <= a;
      t_wdata <= d;
      @(posedge clk_sys_i);
      t_wr <= 1'b0;
      t_rd <= 1'b0;
      #1 v = wr ? {7'h00, restart} : rdata;
   endtask : access
   // counts reset cycles; a repeated reset would push the count past ten
   task automatic count_reset;
      n = 0;
      n_l = 0;
      repeat (14) begin
         #1 n += (sys_rst === 1'b1);
         n_l += (sys_rst_l === 1'b1);
         @(posedge clk_sys_i);
      end
   endtask : count_reset
   // cycle ceiling well above the few hundred cycles the tests need
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         finish_test();
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      #1 check(status, 8'h82);
      check({7'h00, sys_rst}, 8'h00);
      access(1'b0, STATUS_ADDR, 8'h00);
      check(v, 8'h82);
      access(1'b1, STATUS_ADDR, 8'hFF);
      check(v, 8'h01);
      #8 check({7'h00, restart}, 8'h00);
      check(status, 8'h82);
      access(1'b1, CONTROL_ADDR, 8'h01);
      count_reset();
      check(n[7:0], 8'h00);
      access(1'b0, CONTROL_ADDR, 8'h00);
      check(v, READ_ZERO);
      access(1'b0, 16'h0000, 8'h00);
      check(v, 8'h00);
      foreach (ROWS[i]) begin
         @(posedge clk_sys_i);
         src <= ROWS[i].src;
         t_rd <= ROWS[i].acc;
         t_addr <= ROWS[i].addr;
         @(posedge clk_sys_i);
         src <= 10'h000;
         t_rd <= 1'b0;
         count_reset();
         check(n[7:0], ROWS[i].hit ? 8'(RESET_HOLD_CYCLES) : 8'h00);
         check(status, ROWS[i].status);
         check(status & 8'h05, 8'h00);
         v = (ROWS[i].hit && !ROWS[i].acc) ? HOLD_N : 8'h00;
         check(n_l[7:0], v);
         check(status_l & 8'h08, 8'h00);
      end
      // only bit 0 of a debug write may force the reset
      foreach (ROWS[i]) begin
         if (i < 2) begin
            @(posedge clk_sys_i);
            go <= 1'b1;
            go_data <= i == 0 ? 8'hFE : 8'h01;
            @(posedge clk_sys_i);
            go <= 1'b0;
            @(posedge clk_sys_i);
            count_reset();
            check(n[7:0], i == 0 ? 8'h00 : 8'(RESET_HOLD_CYCLES));
            check(status, i == 0 ? 8'h02 : 8'h00);
         end
      end
      // low enable freezes the block: an active pin starts nothing
      @(posedge clk_sys_i);
      ce <= 1'b0;
      src <= 10'h200;
      @(posedge clk_sys_i);
      ce <= 1'b1;
      src <= 10'h000;
      count_reset();
      check(n[7:0], 8'h00);
      check(status, 8'h00);
      // power-on on the edge that starts a pin reset wins over the pin cause
      @(posedge clk_sys_i);
      src <= 10'h200;
      @(posedge clk_sys_i);
      src <= 10'h000;
      rst_i <= 1'b1;
      #1 check({7'h00, sys_rst}, 8'h00);
      check(status, 8'h82);
      repeat (3) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      #1 check(status_l, 8'h82);
      access(1'b0, STATUS_ADDR, 8'h00);
      check(v, 8'h82);
      finish_test();
   end
endmodule : tb
